/* core/bst_tap.sv */
/*
  boundary-scan test access port: controller, instruction register,
  bypass, identification and boundary registers on the test clock, and
  the pin multiplexers on the system clock.
  assumes: rst_n is the chip power-on reset, held while both clocks run;
  tms and tdi are set up to the rising test clock edge.
*/
`timescale 1ns/1ns
`include "bst_tap_defs.svh"

module bst_tap #(
  parameter int N_PINS = `BST_PINS_DEF,
  parameter logic [`BST_IR_W-1:0] CODE_EXTEST = `BST_IR_EXTEST,
  parameter logic [`BST_IR_W-1:0] CODE_SAMPLE = `BST_IR_SAMPLE,
  parameter logic [`BST_IR_W-1:0] CODE_IDCODE = `BST_IR_IDCODE,
  parameter logic [`BST_IR_W-1:0] CODE_USER = `BST_IR_USERCODE,
  parameter logic [`BST_IR_W-1:0] CODE_CLAMP = `BST_IR_CLAMP,
  parameter logic [`BST_IR_W-1:0] CODE_HIGHZ = `BST_IR_HIGHZ,
  parameter logic [`BST_ID_W-1:0] IDCODE_VAL = `BST_IDCODE_DEF
) (
  // system clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // test link
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe_n,
  // core logic side
  input wire logic [N_PINS-1:0] core_out,
  input wire logic [N_PINS-1:0] core_oe_n,
  output logic [N_PINS-1:0] core_in,
  // pads
  input wire logic [N_PINS-1:0] pin_in,
  output logic [N_PINS-1:0] pin_out,
  output logic [N_PINS-1:0] pin_oe_n,
  // configuration status
  input wire logic config_done,
  input wire logic [`BST_ID_W-1:0] user_signature
);

  localparam int CH = `BST_CELL_W * N_PINS;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (N_PINS < 1) begin : g_chk_pins
    $error("N_PINS must be at least one");
  end
  if (CODE_EXTEST == `BST_IR_BYPASS || CODE_SAMPLE == `BST_IR_BYPASS ||
      CODE_IDCODE == `BST_IR_BYPASS || CODE_USER == `BST_IR_BYPASS ||
      CODE_CLAMP == `BST_IR_BYPASS || CODE_HIGHZ == `BST_IR_BYPASS)
  begin : g_chk_codes
    $error("an instruction code collides with bypass");
  end

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // controller next state from current state and select level
  function automatic bst_pkg::bst_state_e bst_next(
    input bst_pkg::bst_state_e s,
    input logic m
  );
    bst_pkg::bst_state_e n;
    n = bst_pkg::ST_TLR;
    case (s)
      bst_pkg::ST_TLR: n = m ? bst_pkg::ST_TLR : bst_pkg::ST_RTI;
      bst_pkg::ST_RTI: n = m ? bst_pkg::ST_SDRS : bst_pkg::ST_RTI;
      bst_pkg::ST_SDRS: n = m ? bst_pkg::ST_SIRS : bst_pkg::ST_CDR;
      bst_pkg::ST_CDR: n = m ? bst_pkg::ST_E1DR : bst_pkg::ST_SDR;
      bst_pkg::ST_SDR: n = m ? bst_pkg::ST_E1DR : bst_pkg::ST_SDR;
      bst_pkg::ST_E1DR: n = m ? bst_pkg::ST_UDR : bst_pkg::ST_PDR;
      bst_pkg::ST_PDR: n = m ? bst_pkg::ST_E2DR : bst_pkg::ST_PDR;
      bst_pkg::ST_E2DR: n = m ? bst_pkg::ST_UDR : bst_pkg::ST_SDR;
      bst_pkg::ST_UDR: n = m ? bst_pkg::ST_SDRS : bst_pkg::ST_RTI;
      bst_pkg::ST_SIRS: n = m ? bst_pkg::ST_TLR : bst_pkg::ST_CIR;
      bst_pkg::ST_CIR: n = m ? bst_pkg::ST_E1IR : bst_pkg::ST_SIR;
      bst_pkg::ST_SIR: n = m ? bst_pkg::ST_E1IR : bst_pkg::ST_SIR;
      bst_pkg::ST_E1IR: n = m ? bst_pkg::ST_UIR : bst_pkg::ST_PIR;
      bst_pkg::ST_PIR: n = m ? bst_pkg::ST_E2IR : bst_pkg::ST_PIR;
      bst_pkg::ST_E2IR: n = m ? bst_pkg::ST_UIR : bst_pkg::ST_SIR;
      bst_pkg::ST_UIR: n = m ? bst_pkg::ST_SDRS : bst_pkg::ST_RTI;
      default: n = bst_pkg::ST_TLR;
    endcase
    return n;
  endfunction : bst_next

  // instruction decode; unknown codes fall back to bypass
  function automatic bst_pkg::bst_instr_e bst_decode(
    input logic [`BST_IR_W-1:0] c
  );
    bst_pkg::bst_instr_e r;
    r = bst_pkg::I_BYPASS;
    if (c == CODE_EXTEST) r = bst_pkg::I_EXTEST;
    else if (c == CODE_SAMPLE) r = bst_pkg::I_SAMPLE;
    else if (c == CODE_IDCODE) r = bst_pkg::I_IDCODE;
    else if (c == CODE_USER) r = bst_pkg::I_USERCODE;
    else if (c == CODE_CLAMP) r = bst_pkg::I_CLAMP;
    else if (c == CODE_HIGHZ) r = bst_pkg::I_HIGHZ;
    return r;
  endfunction : bst_decode

  // ----------------------------------------------------------------
  // declarations, test clock domain
  // ----------------------------------------------------------------
  logic por_s1_q;
  logic por_s2_q;
  bst_pkg::bst_state_e state_q;
  bst_pkg::bst_instr_e instr;
  logic [`BST_IR_W-1:0] ir_sh_q;
  logic [`BST_IR_W-1:0] ir_q;
  logic byp_q;
  logic [`BST_ID_W-1:0] id_q;
  logic [CH-1:0] bsr_q;
  logic [CH-1:0] upd_q;
  logic [CH-1:0] obs_s1_q;
  logic [CH-1:0] obs_s2_q;
  logic cfg_s1_q;
  logic cfg_s2_q;
  logic ctl_upd_q;
  logic ctl_hiz_q;
  logic xfer_q;
  logic tdo_q;
  logic tdo_oe_n_q;
  logic dr_bit;
  logic sel_bsr;
  logic sel_id;

  // ----------------------------------------------------------------
  // declarations, system clock domain
  // ----------------------------------------------------------------
  logic [N_PINS-1:0] pin_s1_q;
  logic [N_PINS-1:0] core_in_q;
  logic [N_PINS-1:0] pin_out_q;
  logic [N_PINS-1:0] pin_oe_n_q;
  logic xfer_s1_q;
  logic xfer_s2_q;
  logic xfer_s3_q;
  logic [1:0] mode_s2_q;
  logic [CH-1:0] upd_s2_q;
  logic [CH-1:0] obs;

  // ----------------------------------------------------------------
  // power-on reset into the test clock domain
  // ----------------------------------------------------------------
  // two-flop carry of the chip reset; no dedicated test reset pin
  always_ff @(posedge tck) begin
    por_s1_q <= rst_n;
    por_s2_q <= por_s1_q;
  end

  // ----------------------------------------------------------------
  // controller
  // ----------------------------------------------------------------
  // one step per rising test clock, tms decides the branch
  always_ff @(posedge tck) begin
    if (!por_s2_q) begin
      state_q <= bst_pkg::ST_TLR;
    end else begin
      state_q <= bst_next(state_q, tms);
    end
  end

  // ----------------------------------------------------------------
  // instruction register
  // ----------------------------------------------------------------
  // shift stage: capture pattern, shift lsb first
  always_ff @(posedge tck) begin
    if (!por_s2_q) begin
      ir_sh_q <= `BST_IR_IDCODE;
    end else begin
      case (state_q)
        bst_pkg::ST_CIR: ir_sh_q <= `BST_IR_CAPTURE;
        bst_pkg::ST_SIR: ir_sh_q <= {tdi, ir_sh_q[`BST_IR_W-1:1]};
        default: ir_sh_q <= ir_sh_q;
      endcase
    end
  end

  // active instruction: loaded at update, forced in reset state
  always_ff @(posedge tck) begin
    if (!por_s2_q) begin
      ir_q <= CODE_IDCODE;
    end else if (state_q == bst_pkg::ST_TLR) begin
      ir_q <= CODE_IDCODE;
    end else if (state_q == bst_pkg::ST_UIR) begin
      ir_q <= ir_sh_q;
    end
  end

  assign instr = bst_decode(ir_q);

  // data register selection
  assign sel_bsr = (instr == bst_pkg::I_SAMPLE) ||
                   (instr == bst_pkg::I_EXTEST);
  assign sel_id = (instr == bst_pkg::I_IDCODE) ||
                  (instr == bst_pkg::I_USERCODE);

  // pin mode levels, set with the instruction they belong to so that
  // the pins follow without a further test clock
  always_ff @(posedge tck) begin
    if (!por_s2_q) begin
      ctl_upd_q <= 1'b0;
      ctl_hiz_q <= 1'b0;
    end else if (state_q == bst_pkg::ST_TLR) begin
      ctl_upd_q <= 1'b0;
      ctl_hiz_q <= 1'b0;
    end else if (state_q == bst_pkg::ST_UIR) begin
      ctl_upd_q <= (bst_decode(ir_sh_q) == bst_pkg::I_EXTEST) ||
                   (bst_decode(ir_sh_q) == bst_pkg::I_CLAMP);
      ctl_hiz_q <= (bst_decode(ir_sh_q) == bst_pkg::I_HIGHZ);
    end
  end

  // toggled whenever mode levels or update stages may move
  always_ff @(posedge tck) begin
    if (!por_s2_q) begin
      xfer_q <= 1'b0;
    end else if (state_q == bst_pkg::ST_TLR || state_q == bst_pkg::ST_UIR ||
                 state_q == bst_pkg::ST_UDR) begin
      xfer_q <= !xfer_q;
    end
  end

  // ----------------------------------------------------------------
  // bypass register
  // ----------------------------------------------------------------
  // single stage, zero on capture
  always_ff @(posedge tck) begin
    if (!por_s2_q) begin
      byp_q <= 1'b0;
    end else if (state_q == bst_pkg::ST_CDR) begin
      byp_q <= 1'b0;
    end else if (state_q == bst_pkg::ST_SDR) begin
      byp_q <= tdi;
    end
  end

  // ----------------------------------------------------------------
  // identification register
  // ----------------------------------------------------------------
  // carry configuration status into the test clock domain
  always_ff @(posedge tck) begin
    cfg_s1_q <= config_done;
    cfg_s2_q <= cfg_s1_q;
  end

  // parallel load of id word or user signature, then shift
  always_ff @(posedge tck) begin
    if (!por_s2_q) begin
      id_q <= IDCODE_VAL;
    end else if (sel_id && state_q == bst_pkg::ST_CDR) begin
      if (instr == bst_pkg::I_IDCODE) begin
        id_q <= IDCODE_VAL;
      end else if (cfg_s2_q) begin
        id_q <= user_signature;
      end else begin
        id_q <= `BST_UNCONFIGURED;
      end
    end else if (sel_id && state_q == bst_pkg::ST_SDR) begin
      id_q <= {tdi, id_q[`BST_ID_W-1:1]};
    end
  end

  // ----------------------------------------------------------------
  // boundary register
  // ----------------------------------------------------------------
  // carry pin observations into the test clock domain
  always_ff @(posedge tck) begin
    obs_s1_q <= obs;
    obs_s2_q <= obs_s1_q;
  end

  // capture stages: load on capture, shift toward data out
  always_ff @(posedge tck) begin
    if (!por_s2_q) begin
      bsr_q <= '0;
    end else if (sel_bsr && state_q == bst_pkg::ST_CDR) begin
      bsr_q <= obs_s2_q;
    end else if (sel_bsr && state_q == bst_pkg::ST_SDR) begin
      bsr_q <= {tdi, bsr_q[CH-1:1]};
    end
  end

  // update stages: copied from capture stages
  always_ff @(posedge tck) begin
    if (!por_s2_q) begin
      upd_q <= '0;
    end else if (sel_bsr && state_q == bst_pkg::ST_UDR) begin
      upd_q <= bsr_q;
    end
  end

  // ----------------------------------------------------------------
  // test data out, falling edge
  // ----------------------------------------------------------------
  // bit of the selected data register
  always_comb begin
    dr_bit = byp_q;
    if (sel_bsr) begin
      dr_bit = bsr_q[0];
    end else if (sel_id) begin
      dr_bit = id_q[0];
    end
  end

  // drive only while in a shift state
  always_ff @(negedge tck) begin
    if (!por_s2_q) begin
      tdo_oe_n_q <= 1'b1;
    end else begin
      tdo_oe_n_q <= !((state_q == bst_pkg::ST_SIR) ||
                      (state_q == bst_pkg::ST_SDR));
    end
  end

  // serial bit presented half a cycle after the shift edge
  always_ff @(negedge tck) begin
    if (!por_s2_q) begin
      tdo_q <= 1'b0;
    end else if (state_q == bst_pkg::ST_SIR) begin
      tdo_q <= ir_sh_q[0];
    end else if (state_q == bst_pkg::ST_SDR) begin
      tdo_q <= dr_bit;
    end
  end

  assign tdo = tdo_q;
  assign tdo_oe_n = tdo_oe_n_q;

  // ----------------------------------------------------------------
  // system domain: crossings
  // ----------------------------------------------------------------
  // pad inputs through two flops before any use
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pin_s1_q <= '0;
      core_in_q <= '0;
    end else begin
      pin_s1_q <= pin_in;
      core_in_q <= pin_s1_q;
    end
  end

  // toggle through two flops; the words it guards have stood still
  // since it moved (test clock much slower), so they are taken whole
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      xfer_s1_q <= 1'b0;
      xfer_s2_q <= 1'b0;
      xfer_s3_q <= 1'b0;
      mode_s2_q <= '0;
      upd_s2_q <= '0;
    end else begin
      xfer_s1_q <= xfer_q;
      xfer_s2_q <= xfer_s1_q;
      xfer_s3_q <= xfer_s2_q;
      if (xfer_s2_q != xfer_s3_q) begin
        mode_s2_q <= {ctl_hiz_q, ctl_upd_q};
        upd_s2_q <= upd_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // system domain: pin multiplexers
  // ----------------------------------------------------------------
  for (genvar i = 0; i < N_PINS; i++) begin : g_pin
    // functional, update-driven or released pin drive
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        pin_out_q[i] <= 1'b0;
        pin_oe_n_q[i] <= 1'b1;
      end else if (mode_s2_q[`BST_MODE_HIZ]) begin
        pin_out_q[i] <= 1'b0;
        pin_oe_n_q[i] <= 1'b1;
      end else if (mode_s2_q[`BST_MODE_UPD]) begin
        pin_out_q[i] <= upd_s2_q[`BST_CELL_W*i+`BST_CELL_OUT];
        pin_oe_n_q[i] <= upd_s2_q[`BST_CELL_W*i+`BST_CELL_OEN];
      end else begin
        pin_out_q[i] <= core_out[i];
        pin_oe_n_q[i] <= core_oe_n[i];
      end
    end

    // observed cell values as driven and as seen at the pad
    assign obs[`BST_CELL_W*i+`BST_CELL_OUT] = pin_out_q[i];
    assign obs[`BST_CELL_W*i+`BST_CELL_OEN] = pin_oe_n_q[i];
    assign obs[`BST_CELL_W*i+`BST_CELL_IN] = core_in_q[i];
  end

  // outputs straight from flops
  assign core_in = core_in_q;
  assign pin_out = pin_out_q;
  assign pin_oe_n = pin_oe_n_q;

endmodule : bst_tap

/* core/bst_tap_defs.svh */
/*
  constants of the boundary-scan test access port: widths, cell field
  positions, fixed instruction values, default instruction codes and
  capture patterns.
  assumes: included by its bare name from the design and testbench files.
*/
// What this block does
// - a ten-bit instruction register decodes all seven test instructions
// - sixteen-state controller steps on each rising test clock by mode select
// - in reset state test logic is off, pins normal, IDCODE loaded
// - controller starts in reset state at power-up, no test reset pin
// - five rising edges with select high reach reset state and stay there
// - data out floats except in shift states, switching on falling edges
// - Shift-IR shifts instruction bits out on falling edges while select low
// - data in sampled on rising edges; last bit goes with select high
// - sample capture records live pin values, pins keep functional data
// - Shift-DR chains all boundary capture stages from data in to out
// - Update-DR copies each capture stage into its update stage
// - after instruction, Capture-DR then Shift-DR; two highs reach Update-DR
// - captured bits leave first; new bits traverse the whole chain
// - external test drives pins from update stages, capture records pins
// - an all-ones instruction selects bypass
// - bypass bit enters on rising edge, leaves on same pulse falling edge
// - IDCODE loads a 32-bit identification word and shifts it out
// - USERCODE loads the 32-bit user signature into the id register
// - user signature reads valid only after configuration completes
// - bypass path is a single stage
// - clamp drives pins from update stages with bypass as serial path
// - high-z disables pin drivers until a new instruction, bypass path
`ifndef BST_TAP_DEFS_SVH
`define BST_TAP_DEFS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define BST_IR_W 10
`define BST_ID_W 32
`define BST_CELL_W 3
`define BST_PINS_DEF 4

// ----------------------------------------------------------------
// cell field positions and mode bit positions
// ----------------------------------------------------------------
`define BST_CELL_OUT 0
`define BST_CELL_OEN 1
`define BST_CELL_IN 2
`define BST_MODE_UPD 0
`define BST_MODE_HIZ 1

// ----------------------------------------------------------------
// instruction values
// ----------------------------------------------------------------
`define BST_IR_BYPASS 10'h3ff
`define BST_IR_CAPTURE 10'h155
`define BST_IR_EXTEST 10'h00f
`define BST_IR_SAMPLE 10'h005
`define BST_IR_IDCODE 10'h006
`define BST_IR_USERCODE 10'h007
`define BST_IR_CLAMP 10'h00a
`define BST_IR_HIGHZ 10'h00b
// arbitrary identification word, lsb set as the chain expects
`define BST_IDCODE_DEF 32'h0abc_d001
`define BST_UNCONFIGURED 32'h0000_0000

`endif

/* core/bst_pkg.sv */
/*
  types of the boundary-scan test access port: controller states and
  decoded instructions, both one-hot.
  assumes: nothing beyond a SystemVerilog compiler.
*/
package bst_pkg;

  // ----------------------------------------------------------------
  // controller states
  // ----------------------------------------------------------------
  typedef enum logic [15:0] {
    ST_TLR  = 16'h0001, ST_RTI  = 16'h0002, ST_SDRS = 16'h0004,
    ST_CDR  = 16'h0008, ST_SDR  = 16'h0010, ST_E1DR = 16'h0020,
    ST_PDR  = 16'h0040, ST_E2DR = 16'h0080, ST_UDR  = 16'h0100,
    ST_SIRS = 16'h0200, ST_CIR  = 16'h0400, ST_SIR  = 16'h0800,
    ST_E1IR = 16'h1000, ST_PIR  = 16'h2000, ST_E2IR = 16'h4000,
    ST_UIR  = 16'h8000
  } bst_state_e;

  // ----------------------------------------------------------------
  // decoded instructions
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    I_SAMPLE = 7'h01, I_EXTEST = 7'h02, I_BYPASS = 7'h04,
    I_IDCODE = 7'h08, I_USERCODE = 7'h10, I_CLAMP = 7'h20,
    I_HIGHZ = 7'h40
  } bst_instr_e;

endpackage : bst_pkg

/* sim/bst_tap_assertions.sv */
/*
  checker of the test port: link enable timing and pin paths.
  assumes: bound to bst_tap; tck toggles while rst_n is low.
*/
`timescale 1ns/1ns

module bst_tap_assertions #(
  parameter int N_PINS = 4
) (
  // clocks and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic tck,
  // test link
  input wire logic tms,
  input wire logic tdo,
  input wire logic tdo_oe_n,
  // pins
  input wire logic [N_PINS-1:0] core_out,
  input wire logic [N_PINS-1:0] core_oe_n,
  input wire logic [N_PINS-1:0] core_in,
  input wire logic [N_PINS-1:0] pin_in,
  input wire logic [N_PINS-1:0] pin_out,
  input wire logic [N_PINS-1:0] pin_oe_n
);
  logic [3:0] hi_q;

  // run of rising edges with select high
  always_ff @(posedge tck) begin
    if (!rst_n || !tms) begin
      hi_q <= 4'h0;
    end else if (hi_q != 4'hf) begin
      hi_q <= hi_q + 4'h1;
    end
  end

  chk_tms_float: assert property (@(posedge tck) disable iff (!rst_n)
    tms |=> tdo_oe_n)
    else $error("data out enabled after select high");
  chk_shift_hold: assert property (@(posedge tck) disable iff (!rst_n)
    !tdo_oe_n && !tms |=> !tdo_oe_n)
    else $error("shift state left with select low");
  chk_ir_entry: assert property (@(posedge tck) disable iff (!rst_n)
    (hi_q >= 4'h5 && !tms) ##1 tms [*2] ##1 !tms [*2] |=> !tdo_oe_n && tdo)
    else $error("instruction shift not entered");
  chk_ir_pattern: assert property (@(posedge tck) disable iff (!rst_n)
    (hi_q >= 4'h5 && !tms) ##1 tms [*2] ##1 !tms [*3] |=> !tdo && !tdo_oe_n)
    else $error("second capture bit wrong");
  chk_fall_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tck && $past(tck) |-> $stable(tdo) && $stable(tdo_oe_n))
    else $error("data out moved while test clock high");
  chk_normal_out: assert property (@(posedge clk_sys) disable iff (!rst_n)
    hi_q >= 4'h6 ##4 hi_q >= 4'h6 |-> pin_out == $past(core_out))
    else $error("pin data not functional in reset state");
  chk_normal_oe: assert property (@(posedge clk_sys) disable iff (!rst_n)
    hi_q >= 4'h6 ##4 hi_q >= 4'h6 |-> pin_oe_n == $past(core_oe_n))
    else $error("pin enable not functional in reset state");
  chk_core_sync: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(rst_n) && $past(rst_n, 2) |-> core_in == $past(pin_in, 2))
    else $error("pad input not passed to core");
endmodule : bst_tap_assertions

bind bst_tap bst_tap_assertions #(.N_PINS(N_PINS)) u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .tck(tck), .tms(tms), .tdo(tdo),
  .tdo_oe_n(tdo_oe_n), .core_out(core_out), .core_oe_n(core_oe_n),
  .core_in(core_in), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe_n(pin_oe_n)
);

/* sim/bst_tester.sv */
/*
  model of the external test controller: makes the test clock only
  within frames, drives select and data, records data out.
  assumes: select and data idle at their pull-up level.
*/
`timescale 1ns/1ns

module bst_tester (
  // frame alignment
  input wire logic clk_sys,
  // test link
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe_n
);
  logic [63:0] got;
  logic last_tdo;
  logic last_oe;
  logic oe_bad;

  // idle: clock still low, lines at pull-up level
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    oe_bad = 1'b0;
    got = '0;
  end

  // one clock pulse, line sampled just before it
  task automatic step(input logic m, input logic d);
    #1;
    last_tdo = tdo;
    last_oe = tdo_oe_n;
    tms = m;
    tdi = d;
    #80 tck = 1'b1;
    #79 tck = 1'b0;
  endtask : step

  task automatic shift(input int n, input logic [63:0] d);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, d[i]);
      got[i] = last_tdo;
      if (last_oe !== 1'b0) oe_bad = 1'b1;
    end
  endtask : shift

  // from exit state, update, back to idle
  task automatic tail();
    step(1'b1, 1'b1);
    if (last_oe !== 1'b1) oe_bad = 1'b1;
    step(1'b0, 1'b1);
  endtask : tail

  task automatic reset5();
    @(negedge clk_sys);
    repeat (6) step(1'b1, 1'b1);
  endtask : reset5

  task automatic ir_load(input logic [9:0] c);
    @(negedge clk_sys);
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
    step(1'b0, 1'b1);
    shift(10, 64'(c));
    tail();
  endtask : ir_load

  task automatic dr_scan(input int n, input logic [63:0] d);
    @(negedge clk_sys);
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
    step(1'b0, 1'b1);
    shift(n, d);
    tail();
  endtask : dr_scan
endmodule : bst_tester

/* sim/bst_tap_tb_top.sv */
/*
  testbench of the test port: scans all instructions, checks pins.
  assumes: design defaults, four pins.
*/
`timescale 1ns/1ns
`include "bst_tap_defs.svh"

module bst_tap_tb_top;
  localparam int NP = 4;
  logic clk_sys, rst_n, tck, tms, tdi, tdo, tdo_oe_n, config_done;
  logic [NP-1:0] core_out, core_oe_n, core_in, pin_in, pin_out, pin_oe_n;
  logic [31:0] user_signature;
  logic [63:0] d;
  logic [11:0] upd;
  logic [7:0] up;
  logic [9:0] codes [4];
  int mismatches, n_tests, cycles;

  bst_tap DUT (.clk_sys(clk_sys), .rst_n(rst_n), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .core_out(core_out),
    .core_oe_n(core_oe_n), .core_in(core_in), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .config_done(config_done),
    .user_signature(user_signature));
  bst_tester u_tester (.clk_sys(clk_sys), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n));

  // system clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      $display("[FAIL] %0t timeout", $time);
      stop_test();
    end
  end

  task automatic stop_test();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [63:0] g, input logic [63:0] e,
                       input string what);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask : check

  // chain image of per-pin values, pin 0 nearest data out
  function automatic logic [11:0] cells(input logic [NP-1:0] o, e, p);
    logic [11:0] r;
    for (int i = 0; i < NP; i++) begin
      r[3*i] = o[i];
      r[3*i+1] = e[i];
      r[3*i+2] = p[i];
    end
    return r;
  endfunction : cells

  // pins from update stages as {oe_n, out}
  function automatic logic [7:0] upins(input logic [11:0] u);
    logic [7:0] r;
    for (int i = 0; i < NP; i++) begin
      r[i] = u[3*i];
      r[NP+i] = u[3*i+1];
    end
    return r;
  endfunction : upins

  task automatic drive_core();
    @(posedge clk_sys);
    #1;
    core_out = 4'($urandom);
    core_oe_n = 4'($urandom);
    pin_in = 4'($urandom);
  endtask : drive_core

  task automatic settle();
    repeat (8) @(posedge clk_sys);
    #1;
  endtask : settle

  // main sequence
  initial begin
    void'($urandom(78));
    {rst_n, config_done, cycles, mismatches, n_tests} = '0;
    {core_out, core_oe_n, pin_in, user_signature} = '0;
    codes = '{10'h3ff, `BST_IR_CLAMP, 10'h3fe, `BST_IR_HIGHZ};
    repeat (5) u_tester.step(1'b1, 1'b1);
    @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    u_tester.reset5();
    u_tester.dr_scan(32, 64'($urandom));
    check(64'(u_tester.got[31:0]), 64'(`BST_IDCODE_DEF), "id");
    u_tester.reset5();
    u_tester.ir_load(`BST_IR_USERCODE);
    check(64'(u_tester.got[9:0]), 64'h155, "ir capture");
    u_tester.dr_scan(32, 64'($urandom));
    check(64'(u_tester.got[31:0]), 64'(`BST_UNCONFIGURED), "early");
    @(posedge clk_sys);
    #1;
    config_done = 1'b1;
    user_signature = $urandom;
    u_tester.dr_scan(32, 64'($urandom));
    check(64'(u_tester.got[31:0]), 64'(user_signature), "sig");
    drive_core();
    u_tester.ir_load(`BST_IR_SAMPLE);
    check(64'({pin_oe_n, pin_out}), 64'({core_oe_n, core_out}), "fn");
    d = {$urandom, $urandom};
    u_tester.dr_scan(24, d);
    check(64'(u_tester.got[11:0]), 64'(cells(core_out, core_oe_n, pin_in)),
      "sample");
    check(64'(u_tester.got[23:12]), 64'(d[11:0]), "chain");
    upd = d[23:12];
    drive_core();
    u_tester.ir_load(`BST_IR_EXTEST);
    settle();
    up = upins(upd);
    check(64'({pin_oe_n, pin_out}), 64'(up), "extest");
    d = 64'($urandom);
    u_tester.dr_scan(12, d);
    check(64'(u_tester.got[11:0]), 64'(cells(up[3:0], up[7:4], pin_in)),
      "ext capture");
    upd = d[11:0];
    settle();
    check(64'({pin_oe_n, pin_out}), 64'(upins(upd)), "update");
    foreach (codes[k]) begin
      drive_core();
      u_tester.ir_load(codes[k]);
      settle();
      up = (k == 1) ? upins(upd) : (k == 3) ? 8'hf0 : {core_oe_n, core_out};
      check(64'({pin_oe_n, pin_out}), 64'(up), "mode pins");
      d = 64'($urandom);
      u_tester.dr_scan(9, d);
      check(64'(u_tester.got[8:0]), 64'({d[7:0], 1'b0}), "byp");
    end
    u_tester.reset5();
    settle();
    check(64'({pin_oe_n, pin_out}), 64'({core_oe_n, core_out}), "rst");
    check(64'(u_tester.oe_bad), 64'h0, "data out enable");
    stop_test();
  end
endmodule : bst_tap_tb_top
